//--- inc/timer_pkg.sv
// constants and types shared by the down-counter timer and its prescaler
package timer_pkg;

    // bus geometry: byte address, registers on aligned words
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned IDX_W  = 8;

    // register indices; the byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_PRESCALER  = 8'hd2;
    localparam logic [IDX_W-1:0] IDX_COUNT      = 8'hd3;
    localparam logic [IDX_W-1:0] IDX_CONTROL    = 8'hd4;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'hd5;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 8'hd6;

    // control/status field positions
    localparam int unsigned BIT_ZERO_FLAG = 7;
    localparam int unsigned BIT_IRQ_EN    = 6;
    localparam int unsigned BIT_DIR       = 5;
    localparam int unsigned BIT_DOUT      = 4;
    localparam int unsigned BIT_RUN       = 3;
    localparam int unsigned TAP_LSB       = 0;
    localparam int unsigned TAP_W         = 3;

    // widths and values after reset
    localparam int unsigned COUNT_W         = 8;
    localparam int unsigned PRESCALER_W     = 7;
    localparam logic [7:0]  COUNT_RESET     = 8'hff;
    localparam logic [6:0]  PRESCALER_RESET = 7'h7f;
    localparam logic [7:0]  CONTROL_RESET   = 8'h00;

    // internal clock divided by twelve feeds the prescaler in gated and output modes
    localparam int unsigned INTERNAL_DIVIDE = 12;
    localparam int unsigned DIV_W           = 4;
    localparam logic [3:0]  DIV_LAST        = 4'(INTERNAL_DIVIDE - 1);

    // interrupt status / mask bits
    localparam int unsigned IRQ_W    = 2;
    localparam int unsigned IRQ_ZERO = 0;
    localparam int unsigned IRQ_WRAP = 1;
    localparam logic [1:0]  IRQ_RESET = 2'h0;

    typedef enum logic [1:0] {
        MODE_EVENT,
        MODE_GATED,
        MODE_OUTPUT
    } mode_t;

    typedef enum logic {
        BUS_IDLE,
        BUS_DONE
    } bus_state_t;

endpackage : timer_pkg

//--- hw/prescaler_tap.sv
// 7-bit down-counting prescaler with selectable tap driving the counter tick
`timescale 1ns/10ps
module prescaler_tap
    import timer_pkg::*;
(
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   srst,
    // control
    input  wire logic                   run,
    input  wire logic                   tick,
    input  wire logic [TAP_W-1:0]       tapSel,
    input  wire logic                   load,
    input  wire logic [PRESCALER_W-1:0] loadValue,
    // results
    output logic      [PRESCALER_W-1:0] value,
    output logic                        counterTick
);

    typedef struct packed {
        logic [PRESCALER_W-1:0] value;
    } pre_state_t;

    pre_state_t                 st;
    pre_state_t                 next_st;
    logic       [PRESCALER_W-1:0] bitRise;

    // a bit rises on a decrement when it and every lower bit are zero
    genvar i;
    generate
        for (i = 0; i < PRESCALER_W; i++) begin : g_rise
            assign bitRise[i] = tick & (st.value[i:0] == '0);
        end
    endgenerate

    always_comb begin
        next_st = st;
        if (!run) begin
            next_st.value = PRESCALER_RESET;
        end else begin
            if (tick) begin
                next_st.value = st.value - 7'h01;
            end
            if (load) begin
                next_st.value = loadValue;
            end
        end
    end

    always_comb begin
        if (!run) begin
            counterTick = 1'b0;
        end else if (tapSel == 3'h0) begin
            counterTick = tick;
        end else begin
            counterTick = bitRise[tapSel - 3'h1];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st.value <= PRESCALER_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign value = st.value;

endmodule : prescaler_tap

//--- hw/timer_counter.sv
// 8-bit down-counter timer with prescaler, pin modes and Avalon-MM registers
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module timer_counter
    import timer_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              srst,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [3:0]        byteenable,
    input  wire logic [DATA_W-1:0] writedata,
    output logic      [DATA_W-1:0] readdata,
    output logic                   waitrequest,
    // timer pin
    input  wire logic              pinIn,
    output logic                   pinOut,
    output logic                   pinOeN,
    // requests
    output logic                   timerRequest,
    output logic                   wakeRequest,
    output logic                   irq
);

    typedef struct packed {
        logic [COUNT_W-1:0] count;
        logic               zeroFlag;
        logic               irqEnable;
        logic               direction;
        logic               doutBit;
        logic               run;
        logic [TAP_W-1:0]   tapSel;
        logic               pinLatch;
        logic [1:0]         pinSync;
        logic               pinPrev;
        logic [DIV_W-1:0]   divCount;
        logic [IRQ_W-1:0]   irqStatus;
        logic [IRQ_W-1:0]   irqMask;
        bus_state_t         busState;
        logic [DATA_W-1:0]  readdata;
    } state_t;

    state_t st;
    state_t next_st;

    // decode
    logic [IDX_W-1:0]       regIndex;
    logic                   doWrite;
    logic                   lowLane;
    logic [7:0]             wbyte;
    logic                   writeCount;
    logic                   writeControl;
    logic                   writePrescaler;
    logic                   writeStatus;
    logic                   writeMask;

    // datapath
    mode_t                  mode;
    logic                   pinLevel;
    logic                   pinRise;
    logic                   divTick;
    logic                   preTick;
    logic                   counterTick;
    logic [PRESCALER_W-1:0] preValue;
    logic                   zeroSet;
    logic [IRQ_W-1:0]       irqSet;
    logic [7:0]             controlView;
    logic [7:0]             readByte;

    assign regIndex = address[ADDR_W-1:2];
    assign lowLane  = byteenable[0];
    assign wbyte    = writedata[7:0];

    // a write takes effect on the edge where waitrequest is sampled low
    assign doWrite        = write & (st.busState == BUS_DONE) & lowLane;
    assign writeCount     = doWrite & (regIndex == IDX_COUNT);
    assign writeControl   = doWrite & (regIndex == IDX_CONTROL);
    assign writePrescaler = doWrite & (regIndex == IDX_PRESCALER) & st.run;
    assign writeStatus    = doWrite & (regIndex == IDX_IRQ_STATUS);
    assign writeMask      = doWrite & (regIndex == IDX_IRQ_MASK);

    // one wait cycle per access, then completion
    assign waitrequest = (read | write) & (st.busState == BUS_IDLE);

    // mode select from direction and output bit
    always_comb begin
        if (st.direction) begin
            mode = MODE_OUTPUT;
        end else if (st.doutBit) begin
            mode = MODE_GATED;
        end else begin
            mode = MODE_EVENT;
        end
    end

    // pin synchroniser output and edge
    assign pinLevel = st.pinSync[1];
    assign pinRise  = st.pinSync[1] & ~st.pinPrev;
    assign divTick  = (st.divCount == DIV_LAST);

    // prescaler input source
    always_comb begin
        case (mode)
            MODE_EVENT: begin
                preTick = pinRise;
            end
            MODE_GATED: begin
                preTick = divTick & pinLevel;
            end
            MODE_OUTPUT: begin
                preTick = divTick;
            end
            default: begin
                preTick = 1'b0;
            end
        endcase
    end

    prescaler_tap u_prescaler (
        .clock       (clock),
        .srst        (srst),
        .run         (st.run),
        .tick        (preTick),
        .tapSel      (st.tapSel),
        .load        (writePrescaler),
        .loadValue   (wbyte[PRESCALER_W-1:0]),
        .value       (preValue),
        .counterTick (counterTick)
    );

    // control register view
    always_comb begin
        controlView                 = 8'h00;
        controlView[BIT_ZERO_FLAG]  = st.zeroFlag;
        controlView[BIT_IRQ_EN]     = st.irqEnable;
        controlView[BIT_DIR]        = st.direction;
        controlView[BIT_DOUT]       = st.doutBit;
        controlView[BIT_RUN]        = st.run;
        controlView[TAP_LSB +: TAP_W] = st.tapSel;
    end

    // read mux; unmapped indices read zero
    always_comb begin
        case (regIndex)
            IDX_PRESCALER: begin
                readByte = {1'b0, preValue};
            end
            IDX_COUNT: begin
                readByte = st.count;
            end
            IDX_CONTROL: begin
                readByte = controlView;
            end
            IDX_IRQ_STATUS: begin
                readByte = {6'h00, st.irqStatus};
            end
            IDX_IRQ_MASK: begin
                readByte = {6'h00, st.irqMask};
            end
            default: begin
                readByte = 8'h00;
            end
        endcase
    end

    always_comb begin
        next_st = st;
        zeroSet = 1'b0;
        irqSet  = '0;

        // two-stage synchroniser, then edge history
        next_st.pinSync = {st.pinSync[0], pinIn};
        next_st.pinPrev = st.pinSync[1];

        // divide-by-twelve of the internal clock
        if (divTick) begin
            next_st.divCount = '0;
        end else begin
            next_st.divCount = st.divCount + 4'h1;
        end

        // counter decrement with wrap
        if (counterTick) begin
            next_st.count = st.count - 8'h01;
            zeroSet       = (st.count == 8'h01);
            irqSet[IRQ_WRAP] = (st.count == 8'h00);
        end

        // a count write wins over a coincident decrement
        if (writeCount) begin
            next_st.count = wbyte;
            zeroSet       = (wbyte == 8'h00);
            // the overridden decrement does not wrap either
            irqSet[IRQ_WRAP] = 1'b0;
        end

        // control write; a hardware set wins over a software clear
        if (writeControl) begin
            next_st.zeroFlag  = wbyte[BIT_ZERO_FLAG] | zeroSet;
            next_st.irqEnable = wbyte[BIT_IRQ_EN];
            next_st.direction = wbyte[BIT_DIR];
            next_st.doutBit   = wbyte[BIT_DOUT];
            next_st.run       = wbyte[BIT_RUN];
            next_st.tapSel    = wbyte[TAP_LSB +: TAP_W];
        end else begin
            next_st.zeroFlag  = st.zeroFlag | zeroSet;
        end

        // output latch transparent while the zero flag is high
        if (st.zeroFlag) begin
            next_st.pinLatch = st.doutBit;
        end

        // sticky interrupt status, write one to clear, set wins
        irqSet[IRQ_ZERO] = next_st.zeroFlag & ~st.zeroFlag;
        if (writeStatus) begin
            next_st.irqStatus = (st.irqStatus & ~wbyte[IRQ_W-1:0]) | irqSet;
        end else begin
            next_st.irqStatus = st.irqStatus | irqSet;
        end
        if (writeMask) begin
            next_st.irqMask = wbyte[IRQ_W-1:0];
        end

        // bus handshake and read capture
        if ((read | write) && st.busState == BUS_IDLE) begin
            next_st.busState = BUS_DONE;
            if (read) begin
                next_st.readdata = {24'h000000, readByte};
            end
        end else begin
            next_st.busState = BUS_IDLE;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st.count     <= COUNT_RESET;
            st.zeroFlag  <= CONTROL_RESET[BIT_ZERO_FLAG];
            st.irqEnable <= CONTROL_RESET[BIT_IRQ_EN];
            st.direction <= CONTROL_RESET[BIT_DIR];
            st.doutBit   <= CONTROL_RESET[BIT_DOUT];
            st.run       <= CONTROL_RESET[BIT_RUN];
            st.tapSel    <= CONTROL_RESET[TAP_LSB +: TAP_W];
            st.pinLatch  <= 1'b0;
            st.pinSync   <= 2'h0;
            st.pinPrev   <= 1'b0;
            st.divCount  <= '0;
            st.irqStatus <= IRQ_RESET;
            st.irqMask   <= IRQ_RESET;
            st.busState  <= BUS_IDLE;
            st.readdata  <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign readdata     = st.readdata;
    assign pinOut       = st.pinLatch;
    assign pinOeN       = ~st.direction;
    assign timerRequest = st.zeroFlag & st.irqEnable;
    assign wakeRequest  = timerRequest;
    assign irq          = |(st.irqStatus & st.irqMask);

endmodule : timer_counter

//--- tb/timer_counter_sva.sv
// checker of bus timing, pin enable and request outputs of the timer
`timescale 1ns/10ps
module timer_counter_sva
    import timer_pkg::*;
(
    // clock and reset
    input wire logic              clock,
    input wire logic              srst,
    // bus
    input wire logic [ADDR_W-1:0] address,
    input wire logic              read,
    input wire logic              write,
    input wire logic [DATA_W-1:0] readdata,
    input wire logic              waitrequest,
    // pin and requests
    input wire logic              pinOeN,
    input wire logic              pinOut,
    input wire logic              timerRequest,
    input wire logic              wakeRequest,
    input wire logic              irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence access_start;
        (read || write) && waitrequest;
    endsequence
    sequence access_done;
        (read || write) && !waitrequest;
    endsequence

    wake_same_a: assert property (timerRequest == wakeRequest)
        else $error("wake request differs from timer request");
    reset_quiet_a: assert property (disable iff (1'b0) srst |=> pinOeN && !pinOut && !timerRequest && !irq)
        else $error("outputs not quiet after reset");
    one_wait_a: assert property (access_start |=> access_done)
        else $error("access did not complete after one wait state");
    first_wait_a: assert property ($rose(read || write) |-> waitrequest)
        else $error("no wait state in first access cycle");
    idle_ready_a: assert property (!(read || write) |-> !waitrequest)
        else $error("waitrequest high without a request");
    upper_zero_a: assert property (readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    prescaler_top_a: assert property ((read && !waitrequest && address[9:2] == IDX_PRESCALER) |-> !readdata[7])
        else $error("prescaler top bit read as one");
    oe_write_a: assert property ($changed(pinOeN) |-> $past(write && !waitrequest))
        else $error("pin enable changed without a register write");
endmodule : timer_counter_sva

bind timer_counter timer_counter_sva timer_counter_sva_i (
    .clock(clock), .srst(srst), .address(address), .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest), .pinOeN(pinOeN), .pinOut(pinOut), .timerRequest(timerRequest),
    .wakeRequest(wakeRequest), .irq(irq));

//--- tb/pin_source.sv
// signal source on the timer pin; the device owns the wire while its enable is low
`timescale 1ns/10ps
module pin_source (
    // clock
    input  wire logic clock,
    // device side of the pin
    input  wire logic pinOut,
    input  wire logic pinOeN,
    // resolved wire level
    output logic      pinLevel
);
    logic drive = 1'b0;

    assign pinLevel = pinOeN ? drive : pinOut;

    // each level held four clocks so the synchroniser sees it
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clock);
            drive <= 1'b1;
            repeat (4) @(posedge clock);
            drive <= 1'b0;
            repeat (3) @(posedge clock);
        end
    endtask : pulse

    task automatic hold(input logic v);
        @(posedge clock);
        drive <= v;
    endtask : hold
endmodule : pin_source

//--- tb/testbench.sv
// self-checking bench of the down-counter timer
`timescale 1ns/10ps
`define CHECK(a, b) begin checksDone++; if ((a) !== (b)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
    import timer_pkg::*;
    logic              clock, srst, read, write, pinLevel, pinOut, pinOeN;
    logic              waitrequest, timerRequest, wakeRequest, irq;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata, readdata;
    logic [7:0]        rd;
    logic [3:0]        byteenable;
    logic [3:0]        lanes = 4'hf;
    int                failures = 0;
    int                checksDone = 0;

    timer_counter timer_counter_i (
        .clock(clock), .srst(srst), .address(address), .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .pinIn(pinLevel),
        .pinOut(pinOut), .pinOeN(pinOeN), .timerRequest(timerRequest), .wakeRequest(wakeRequest), .irq(irq));
    pin_source pin_source_i (.clock(clock), .pinOut(pinOut), .pinOeN(pinOeN), .pinLevel(pinLevel));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clock);
        address    <= {idx, 2'b00};
        writedata  <= {24'h0, d};
        byteenable <= lanes;
        write      <= we;
        read       <= !we;
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        rd = readdata[7:0];
        write <= 1'b0;
        read  <= 1'b0;
        @(negedge clock);
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask : wr

    task automatic rdv(input logic [7:0] idx);
        bus(1'b0, idx, 8'h00);
    endtask : rdv

    task automatic test_reset;
        rdv(IDX_PRESCALER); `CHECK(rd, 8'h7f)
        rdv(IDX_COUNT); `CHECK(rd, 8'hff)
        rdv(IDX_CONTROL); `CHECK(rd, 8'h00)
        wr(8'h10, 8'h5a); rdv(8'h10); `CHECK(rd, 8'h00)
        // a write without lane 0 completes but leaves the count alone
        lanes = 4'he;
        wr(IDX_COUNT, 8'h12);
        lanes = 4'hf;
        rdv(IDX_COUNT); `CHECK(rd, 8'hff)
        $display("test reset done");
    endtask : test_reset

    task automatic test_flag;
        wr(IDX_PRESCALER, 8'h22); rdv(IDX_PRESCALER); `CHECK(rd, 8'h7f)
        wr(IDX_COUNT, 8'h00); rdv(IDX_CONTROL); `CHECK(rd, 8'h80)
        wr(IDX_CONTROL, 8'h00); wr(IDX_CONTROL, 8'hc0); `CHECK(timerRequest, 1'b1)
        wr(IDX_CONTROL, 8'h40); `CHECK(timerRequest, 1'b0)
        wr(IDX_CONTROL, 8'h08); wr(IDX_PRESCALER, 8'h55); rdv(IDX_PRESCALER); `CHECK(rd, 8'h55)
        wr(IDX_CONTROL, 8'h00); rdv(IDX_PRESCALER); `CHECK(rd, 8'h7f)
        $display("test flag done");
    endtask : test_flag

    task automatic test_event;
        // drop status left over from the flag test before unmasking
        wr(IDX_CONTROL, 8'h48); wr(IDX_IRQ_STATUS, 8'h03); wr(IDX_IRQ_MASK, 8'h01); wr(IDX_COUNT, 8'h02);
        `CHECK(irq, 1'b0)
        pin_source_i.pulse(2);
        repeat (6) @(posedge clock);
        rdv(IDX_COUNT); `CHECK(rd, 8'h00)
        `CHECK(timerRequest, 1'b1)
        `CHECK(wakeRequest, 1'b1)
        `CHECK(irq, 1'b1)
        wr(IDX_IRQ_STATUS, 8'h01); `CHECK(irq, 1'b0)
        pin_source_i.pulse(1);
        repeat (6) @(posedge clock);
        rdv(IDX_COUNT); `CHECK(rd, 8'hff)
        `CHECK(irq, 1'b0)
        wr(IDX_CONTROL, 8'h08); `CHECK(timerRequest, 1'b0)
        wr(IDX_IRQ_STATUS, 8'h03); wr(IDX_CONTROL, 8'h00);
        $display("test event done");
    endtask : test_event

    task automatic test_tap;
        wr(IDX_CONTROL, 8'h09); wr(IDX_COUNT, 8'h03);
        pin_source_i.pulse(4);
        repeat (6) @(posedge clock);
        rdv(IDX_COUNT); `CHECK(rd, 8'h01)
        rdv(IDX_PRESCALER); `CHECK(rd, 8'h7b)
        wr(IDX_CONTROL, 8'h00);
        $display("test tap done");
    endtask : test_tap

    task automatic test_gated;
        wr(IDX_CONTROL, 8'h18); wr(IDX_COUNT, 8'h0a);
        repeat (60) @(posedge clock);
        rdv(IDX_COUNT); `CHECK(rd, 8'h0a)
        pin_source_i.hold(1'b1);
        repeat (60) @(posedge clock);
        rdv(IDX_COUNT); `CHECK(rd < 8'h0a, 1'b1)
        pin_source_i.hold(1'b0);
        wr(IDX_CONTROL, 8'h00);
        $display("test gated done");
    endtask : test_gated

    task automatic test_output;
        // a full count keeps a hardware zero out of the latch checks
        wr(IDX_COUNT, 8'hff);
        wr(IDX_CONTROL, 8'h38); `CHECK(pinOeN, 1'b0)
        wr(IDX_CONTROL, 8'hb8); repeat (3) @(posedge clock); `CHECK(pinOut, 1'b1)
        wr(IDX_CONTROL, 8'h28); repeat (3) @(posedge clock); `CHECK(pinOut, 1'b1)
        wr(IDX_CONTROL, 8'ha8); repeat (3) @(posedge clock); `CHECK(pinOut, 1'b0)
        wr(IDX_CONTROL, 8'h00); `CHECK(pinOeN, 1'b1)
        $display("test output done");
    endtask : test_output

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checksDone, failures);
        if (failures == 0 && checksDone > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    initial begin
        srst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = '0;
        writedata = '0;
        byteenable = 4'hf;
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        test_reset();
        test_flag();
        test_event();
        test_tap();
        test_gated();
        test_output();
        end_of_test();
    end

    // runs are about four hundred cycles; this bound of 25000 cycles cuts a hang
    initial begin
        #100000;
        failures++;
        end_of_test();
    end
endmodule : testbench
